// [hw/dpllms_pkg.sv]
// Operation
// - Reset puts automatic machine in free-run
// - Qualified selected input starts lock acquisition
// - Acquisition, all inputs lost: back to free-run
// - Acquisition, input switch: stay acquiring
// - Acquisition, lock achieved: enter locked
// - Locked, all inputs lost: enter holdover
// - Holdover, qualified input appears: lock recovery
// - Recovery, all inputs lost: back to holdover
// - Locked, input switch: enter lock recovery
// - Recovery, lock achieved: enter locked
// - Recovery, input switch: stay recovering
// - Switch on loss, revertive priority, forcing
// - Mode field: automatic or three forced modes
// - Free-run ignores inputs; combo slave follows
// - Bandwidth and damping apply only when locked
// - Bandwidth rounds down to supported nominal
// - Loss-of-signal flags missing edges in window
// - Frequency window 5 ms or 0.4 s
// - Per-input monitors; APLL input LOS only
// - APLL lock from phase errors, register, pin
// - System DPLL free-runs or follows aux oscillator
// - Feedback divider 48-bit, static while operating
// - Forced holdover ignores valid references
// - Non-revertive default; equal priority never reverts
package dpllms_pkg;
  localparam int NREF = 7;
  localparam int CLK_NS = 8;
  localparam int FREQ_SHORT_NS = 5000000;
  localparam int FREQ_LONG_NS = 400000000;
  localparam int FREQ_SHORT_CYC = FREQ_SHORT_NS / CLK_NS;
  localparam int FREQ_LONG_CYC = FREQ_LONG_NS / CLK_NS;
  localparam int ACT_CYC = 256;
  localparam int APLL_LOCK_CNT = 16;

  typedef enum logic [2:0] {
    free_run_state     = 3'h0,
    lock_acquire_state = 3'h1,
    locked_state       = 3'h2,
    holdover_state     = 3'h3,
    lock_recover_state = 3'h4
  } dpllms_state_t;

  typedef enum logic [1:0] {
    mode_auto          = 2'h0,
    mode_forced_locked = 2'h1,
    mode_forced_free   = 2'h2,
    mode_forced_hold   = 2'h3
  } dpllms_mode_t;

  typedef struct packed {
    logic [NREF-1:0] los;
    logic [NREF-1:0] act;
    logic [NREF-1:0] freq_ok;
  } dpllms_mon_t;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] REFEN_OFF  = 8'h04;
  localparam logic [7:0] PRIO_OFF   = 8'h08;
  localparam logic [7:0] BW_OFF     = 8'h0c;
  localparam logic [7:0] LOSWIN_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF   = 8'h14;
  localparam logic [7:0] MON_OFF    = 8'h18;
  localparam logic [7:0] NUMLO_OFF  = 8'h1c;
  localparam logic [7:0] NUMHI_OFF  = 8'h20;
  localparam logic [7:0] DENLO_OFF  = 8'h24;
  localparam logic [7:0] DENHI_OFF  = 8'h28;
  localparam logic [7:0] FNOM_OFF   = 8'h2c;
  localparam logic [7:0] FTOL_OFF   = 8'h30;
  localparam logic [7:0] APLLTH_OFF = 8'h34;

  // CTRL fields, then the BW damping field
  localparam int C_MODE = 0;
  localparam int C_REVERT = 2;
  localparam int C_FSEL_EN = 3;
  localparam int C_FSEL = 4;
  localparam int C_FWIN_LONG = 8;
  localparam int C_SYS_AUX = 9;
  localparam int C_LOCK_PIN = 10;
  localparam int C_COMBO = 11;
  localparam int BW_DAMP = 8;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] REFEN_RST = 32'h0000_007f;
  localparam logic [31:0] PRIO_RST = 32'h0654_3210;
  localparam logic [7:0] LOSWIN_RST = 8'h10;
  localparam logic [7:0] LOSWIN_MIN = 8'h08;
  localparam logic [7:0] APLLTH_RST = 8'h20;

  // Nominal loop bandwidths in units of 0.1 mHz
  localparam int NBW = 17;
  localparam logic [31:0] BW_TABLE [NBW] = '{
    32'd926, 32'd2780, 32'd5560, 32'd11100, 32'd22200, 32'd44500,
    32'd88900, 32'd178000, 32'd356000, 32'd712000, 32'd944000,
    32'd1420000, 32'd2850000, 32'd3330000, 32'd5710000,
    32'd114000000, 32'd121000000};
endpackage

// [hw/dpllms_top.sv]
`timescale 1ns/100ps
module dpllms_top #(
  parameter int FREQ_SHORT_CYC = dpllms_pkg::FREQ_SHORT_CYC,
  parameter int FREQ_LONG_CYC  = dpllms_pkg::FREQ_LONG_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic [dpllms_pkg::NREF-1:0] ref_i,
  input  wire logic                       apll_ref_i,
  input  wire logic                       auxiliary_oscillator_input_i,
  input  wire logic                       dpll_phase_lock_i,
  input  wire logic [7:0]                 apll_phase_err_i,
  output logic      [2:0]                 dpll_state_o,
  output logic      [2:0]                 sel_ref_o,
  output logic                            sel_valid_o,
  output logic                            loop_bw_en_o,
  output logic      [4:0]                 bw_index_o,
  output logic      [2:0]                 damping_o,
  output logic                            combo_follow_o,
  output logic                            apll_lock_pin_o,
  output logic                            sys_dpll_locked_o,
  output logic      [47:0]                fb_num_o,
  output logic      [47:0]                fb_den_o
);
  localparam int N = dpllms_pkg::NREF;

  // Round a request down to the nearest supported nominal
  function automatic logic [4:0] bw_round(input logic [31:0] req);
    logic [4:0] idx;
    idx = 5'h0;
    for (int k = 1; k < dpllms_pkg::NBW; k++) begin
      if (req >= dpllms_pkg::BW_TABLE[k]) idx = 5'(k);
    end
    return idx;
  endfunction

  // Release of the asynchronous reset through two flops
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  logic [31:0] ctrl_r, prio_r, fnom_r, ftol_r;
  logic [N-1:0] refen_r;
  logic [4:0]  bw_idx_r;
  logic [2:0]  damp_r;
  logic [7:0]  loswin_r, apllth_r;
  logic [47:0] num_r, den_r;
  dpllms_pkg::dpllms_state_t st_r, st_nxt, eff_st;
  dpllms_pkg::dpllms_mode_t  mode;
  assign mode = dpllms_pkg::dpllms_mode_t'(ctrl_r[dpllms_pkg::C_MODE +: 2]);

  // APB: one wait state, write lands on the edge that sees pready
  logic acc, wr_en, rd_hit, busy, fb_lock;
  assign acc   = psel_i && penable_i;
  assign wr_en = acc && pready_o && pwrite_i && !pslverr_o;
  // Divider words are frozen while the loop is operating
  assign busy  = (eff_st != dpllms_pkg::free_run_state);

  logic [31:0] rd_val;
  dpllms_pkg::dpllms_mon_t mon;
  logic [N-1:0] qual;
  logic apll_los, apll_lock_r, aux_los, sel_valid_r;
  logic [2:0] sel_r;

  always_comb begin
    rd_val  = 32'h0;
    rd_hit  = 1'b1;
    fb_lock = 1'b0;
    case (paddr_i)
      dpllms_pkg::CTRL_OFF:   rd_val = ctrl_r;
      dpllms_pkg::REFEN_OFF:  rd_val = 32'(refen_r);
      dpllms_pkg::PRIO_OFF:   rd_val = prio_r;
      dpllms_pkg::BW_OFF:
        rd_val = {21'h0, damp_r, 3'h0, bw_idx_r};
      dpllms_pkg::LOSWIN_OFF: rd_val = 32'(loswin_r);
      dpllms_pkg::STAT_OFF:
        rd_val = {9'h0, qual, 6'h0, sys_dpll_locked_o, apll_lock_r,
                  sel_valid_r, sel_r, 1'b0, eff_st};
      dpllms_pkg::MON_OFF:
        rd_val = {7'h0, apll_los, 1'b0, mon.freq_ok, 1'b0, mon.act,
                  1'b0, mon.los};
      dpllms_pkg::NUMLO_OFF:  begin
        rd_val = num_r[31:0];
        fb_lock = busy;
      end
      dpllms_pkg::NUMHI_OFF:  begin
        rd_val = 32'(num_r[47:32]);
        fb_lock = busy;
      end
      dpllms_pkg::DENLO_OFF:  begin
        rd_val = den_r[31:0];
        fb_lock = busy;
      end
      dpllms_pkg::DENHI_OFF:  begin
        rd_val = 32'(den_r[47:32]);
        fb_lock = busy;
      end
      dpllms_pkg::FNOM_OFF:   rd_val = fnom_r;
      dpllms_pkg::FTOL_OFF:   rd_val = ftol_r;
      dpllms_pkg::APLLTH_OFF: rd_val = 32'(apllth_r);
      default:                rd_hit = 1'b0;
    endcase
  end

  // Bus answer flops
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else if (acc && !pready_o) begin
      pready_o  <= 1'b1;
      pslverr_o <= !rd_hit || (pwrite_i && fb_lock);
      prdata_o  <= pwrite_i ? 32'h0 : rd_val;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Software-written configuration
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r   <= dpllms_pkg::CTRL_RST;
      refen_r  <= N'(dpllms_pkg::REFEN_RST);
      prio_r   <= dpllms_pkg::PRIO_RST;
      bw_idx_r <= 5'h0;
      damp_r   <= 3'h0;
      loswin_r <= dpllms_pkg::LOSWIN_RST;
      num_r    <= 48'h0;
      den_r    <= 48'h0;
      fnom_r   <= 32'h0;
      ftol_r   <= 32'h0;
      apllth_r <= dpllms_pkg::APLLTH_RST;
    end else if (wr_en) begin
      case (paddr_i)
        dpllms_pkg::CTRL_OFF:   ctrl_r <= pwdata_i;
        dpllms_pkg::REFEN_OFF:  refen_r <= pwdata_i[N-1:0];
        dpllms_pkg::PRIO_OFF:   prio_r <= pwdata_i;
        dpllms_pkg::BW_OFF: begin
          bw_idx_r <= bw_round(pwdata_i);
          damp_r   <= pwdata_i[dpllms_pkg::BW_DAMP +: 3];
        end
        // Short windows lose accuracy; clamp to eight clocks
        dpllms_pkg::LOSWIN_OFF:
          loswin_r <= (pwdata_i[7:0] < dpllms_pkg::LOSWIN_MIN) ?
                      dpllms_pkg::LOSWIN_MIN : pwdata_i[7:0];
        dpllms_pkg::NUMLO_OFF:  num_r[31:0]  <= pwdata_i;
        dpllms_pkg::NUMHI_OFF:  num_r[47:32] <= pwdata_i[15:0];
        dpllms_pkg::DENLO_OFF:  den_r[31:0]  <= pwdata_i;
        dpllms_pkg::DENHI_OFF:  den_r[47:32] <= pwdata_i[15:0];
        dpllms_pkg::FNOM_OFF:   fnom_r <= pwdata_i;
        dpllms_pkg::FTOL_OFF:   ftol_r <= pwdata_i;
        dpllms_pkg::APLLTH_OFF: apllth_r <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Shared frequency gate: one window for all seven monitors
  logic [31:0] fwin_cnt_r;
  logic fwin_end;
  logic [31:0] fwin_len;
  assign fwin_len = ctrl_r[dpllms_pkg::C_FWIN_LONG] ?
                    32'(FREQ_LONG_CYC) : 32'(FREQ_SHORT_CYC);
  assign fwin_end = (fwin_cnt_r >= fwin_len - 32'h1);
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) fwin_cnt_r <= 32'h0;
    else fwin_cnt_r <= fwin_end ? 32'h0 : fwin_cnt_r + 32'h1;
  end

  logic [7:0] act_cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) act_cnt_r <= 8'h0;
    else act_cnt_r <= act_cnt_r + 8'h1; // wraps every ACT_CYC
  end

  // Per-input LOS, activity and frequency monitors
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_mon
      logic prev_r, act_seen_r, act_r, fok_r, los_r;
      logic [7:0] gap_r;
      logic [31:0] ecnt_r;
      logic edge_w;
      logic [31:0] diff;
      assign edge_w = ref_i[g] && !prev_r;
      assign diff = (ecnt_r > fnom_r) ? ecnt_r - fnom_r
                                      : fnom_r - ecnt_r;
      always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          prev_r <= 1'b0;
          gap_r  <= 8'h0;
          los_r  <= 1'b1;
        end else begin
          prev_r <= ref_i[g];
          gap_r  <= edge_w ? 8'h0 : (gap_r == 8'hff ? gap_r
                                                   : gap_r + 8'h1);
          los_r  <= !edge_w && (gap_r >= loswin_r);
        end
      end
      // Activity: at least one edge per activity period
      always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          act_seen_r <= 1'b0;
          act_r      <= 1'b0;
        end else if (act_cnt_r == 8'(dpllms_pkg::ACT_CYC - 1)) begin
          act_r      <= act_seen_r || edge_w;
          act_seen_r <= 1'b0;
        end else if (edge_w) begin
          act_seen_r <= 1'b1;
        end
      end
      // Frequency: edge count per window against nominal
      always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
          ecnt_r <= 32'h0;
          fok_r  <= 1'b0;
        end else if (fwin_end) begin
          fok_r  <= (diff <= ftol_r);
          ecnt_r <= 32'h0;
        end else if (edge_w) begin
          ecnt_r <= ecnt_r + 32'h1;
        end
      end
      assign mon.los[g] = los_r;
      assign mon.act[g] = act_r;
      assign mon.freq_ok[g] = fok_r;
      assign qual[g] = refen_r[g] && !los_r && act_r && fok_r;
    end
  endgenerate

  // LOS only on the APLL and auxiliary oscillator inputs
  logic apll_prev_r, aux_prev_r;
  logic [7:0] apll_gap_r, aux_gap_r;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      apll_prev_r <= 1'b0;
      aux_prev_r  <= 1'b0;
      apll_gap_r  <= 8'hff;
      aux_gap_r   <= 8'hff;
    end else begin
      apll_prev_r <= apll_ref_i;
      aux_prev_r  <= auxiliary_oscillator_input_i;
      if (apll_ref_i && !apll_prev_r) apll_gap_r <= 8'h0;
      else if (apll_gap_r != 8'hff) apll_gap_r <= apll_gap_r + 8'h1;
      if (auxiliary_oscillator_input_i && !aux_prev_r) aux_gap_r <= 8'h0;
      else if (aux_gap_r != 8'hff) aux_gap_r <= aux_gap_r + 8'h1;
    end
  end
  assign apll_los = (apll_gap_r >= loswin_r);
  assign aux_los  = (aux_gap_r >= loswin_r);

  // Best candidate: lowest priority value among qualified inputs
  logic [2:0] best;
  logic best_ok;
  logic [3:0] best_p;
  always_comb begin
    best = 3'h0;
    best_ok = 1'b0;
    best_p = 4'hf;
    for (int k = 0; k < N; k++) begin
      if (qual[k] && (!best_ok || prio_r[4*k +: 4] < best_p)) begin
        best = 3'(k);
        best_p = prio_r[4*k +: 4];
        best_ok = 1'b1;
      end
    end
  end

  // Reference choice: forced, on loss, or revertive upgrade
  logic [2:0] fsel, sel_nxt;
  logic sel_ok_nxt, cur_ok, revert_up;
  assign fsel = ctrl_r[dpllms_pkg::C_FSEL +: 3];
  assign cur_ok = sel_valid_r && qual[sel_r];
  // Equal priority counts as one group: never revert within it
  assign revert_up = ctrl_r[dpllms_pkg::C_REVERT] && best_ok &&
                     (best_p < prio_r[4*sel_r +: 4]);
  always_comb begin
    sel_nxt = sel_r;
    sel_ok_nxt = cur_ok;
    if (ctrl_r[dpllms_pkg::C_FSEL_EN]) begin
      sel_nxt = fsel;
      sel_ok_nxt = (32'(fsel) < N) && qual[fsel];
    end else if (!cur_ok) begin
      sel_nxt = best;
      sel_ok_nxt = best_ok;
    end else if (revert_up) begin
      sel_nxt = best;
    end
  end

  logic switched;
  assign switched = sel_valid_r && sel_ok_nxt && (sel_nxt != sel_r);
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_r <= 3'h0;
      sel_valid_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      sel_valid_r <= sel_ok_nxt;
    end
  end

  // Automatic operating-mode machine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dpllms_pkg::free_run_state:
        if (sel_ok_nxt) st_nxt = dpllms_pkg::lock_acquire_state;
      dpllms_pkg::lock_acquire_state:
        if (!sel_ok_nxt) st_nxt = dpllms_pkg::free_run_state;
        else if (switched) st_nxt = dpllms_pkg::lock_acquire_state;
        else if (dpll_phase_lock_i)
          st_nxt = dpllms_pkg::locked_state;
      dpllms_pkg::locked_state:
        if (!sel_ok_nxt) st_nxt = dpllms_pkg::holdover_state;
        else if (switched) st_nxt = dpllms_pkg::lock_recover_state;
      dpllms_pkg::holdover_state:
        if (sel_ok_nxt) st_nxt = dpllms_pkg::lock_recover_state;
      dpllms_pkg::lock_recover_state:
        if (!sel_ok_nxt) st_nxt = dpllms_pkg::holdover_state;
        else if (switched) st_nxt = dpllms_pkg::lock_recover_state;
        else if (dpll_phase_lock_i)
          st_nxt = dpllms_pkg::locked_state;
      default: st_nxt = dpllms_pkg::free_run_state;
    endcase
  end

  // Machine frozen under forced modes, resumes where it stood
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) st_r <= dpllms_pkg::free_run_state;
    else if (mode == dpllms_pkg::mode_auto) st_r <= st_nxt;
  end

  // Forced modes take effect at once over the machine
  always_comb begin
    case (mode)
      dpllms_pkg::mode_forced_locked:
        eff_st = dpllms_pkg::locked_state;
      dpllms_pkg::mode_forced_free:
        eff_st = dpllms_pkg::free_run_state;
      dpllms_pkg::mode_forced_hold:
        eff_st = dpllms_pkg::holdover_state;
      default: eff_st = st_r;
    endcase
  end

  // APLL lock: run of small phase errors sets, one large clears
  logic [4:0] apll_run_r;
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      apll_run_r  <= 5'h0;
      apll_lock_r <= 1'b0;
    end else if (apll_los || apll_phase_err_i > apllth_r) begin
      apll_run_r  <= 5'h0;
      apll_lock_r <= 1'b0;
    end else if (apll_run_r == 5'(dpllms_pkg::APLL_LOCK_CNT - 1)) begin
      apll_lock_r <= 1'b1;
    end else begin
      apll_run_r <= apll_run_r + 5'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dpll_state_o      <= 3'h0;
      sel_ref_o         <= 3'h0;
      sel_valid_o       <= 1'b0;
      loop_bw_en_o      <= 1'b0;
      bw_index_o        <= 5'h0;
      damping_o         <= 3'h0;
      combo_follow_o    <= 1'b0;
      apll_lock_pin_o   <= 1'b0;
      sys_dpll_locked_o <= 1'b0;
      fb_num_o          <= 48'h0;
      fb_den_o          <= 48'h0;
    end else begin
      dpll_state_o   <= eff_st;
      sel_ref_o      <= sel_r;
      sel_valid_o    <= sel_valid_r;
      // Loop filter settings only matter while tracking
      loop_bw_en_o   <= (eff_st == dpllms_pkg::locked_state);
      bw_index_o     <= bw_idx_r;
      damping_o      <= damp_r;
      combo_follow_o <= (eff_st == dpllms_pkg::free_run_state) &&
                        ctrl_r[dpllms_pkg::C_COMBO];
      apll_lock_pin_o <= apll_lock_r &&
                         ctrl_r[dpllms_pkg::C_LOCK_PIN];
      sys_dpll_locked_o <= ctrl_r[dpllms_pkg::C_SYS_AUX] &&
                           !aux_los;
      fb_num_o       <= num_r;
      fb_den_o       <= den_r;
    end
  end
endmodule // dpllms_top

// [sim/dpllms_ref_src.sv]
`timescale 1ns/100ps
module dpllms_ref_src (
  input  wire logic       clk_i,
  input  wire logic [8:0] run_i,
  output logic      [8:0] ref_o
);
  logic tog_r;

  // One shared half-rate toggle; a stopped source sits low, so the
  // loss and activity monitors really see a dead line
  initial tog_r = 1'b0;
  always @(posedge clk_i) begin
    tog_r <= ~tog_r;
  end
  assign ref_o = {9{tog_r}} & run_i;
endmodule // dpllms_ref_src

// [sim/dpllms_checker.sv]
`timescale 1ns/100ps
module dpllms_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic [2:0]  dpll_state_o,
  input wire logic        loop_bw_en_o
);
  logic [1:0] md_r;
  logic [2:0] cnt_r;
  logic       au;
  logic [2:0] st;

  // Last written mode; settle count hides the state output lag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_r  <= 2'h0;
      cnt_r <= 3'h7;
    end else if (psel_i && penable_i && pready_o && pwrite_i &&
                 paddr_i == 8'h00) begin
      md_r  <= pwdata_i[1:0];
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h7) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  assign st = dpll_state_o;
  assign au = md_r == 2'h0 && cnt_r == 3'h7;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Automatic moves, one property per state left
  a_free_exit: assert property (
    au && $past(st) == 3'h0 && st != 3'h0 |-> st == 3'h1)
    else $error("free-run left to wrong state");
  a_acq_exit: assert property (
    au && $past(st) == 3'h1 && st != 3'h1 |-> st inside {3'h0, 3'h2})
    else $error("acquisition left to wrong state");
  a_lock_exit: assert property (
    au && $past(st) == 3'h2 && st != 3'h2 |-> st inside {3'h3, 3'h4})
    else $error("locked left to wrong state");
  a_hold_exit: assert property (
    au && $past(st) == 3'h3 && st != 3'h3 |-> st == 3'h4)
    else $error("holdover left to wrong state");
  a_rec_exit: assert property (
    au && $past(st) == 3'h4 && st != 3'h4 |-> st inside {3'h2, 3'h3})
    else $error("recovery left to wrong state");
  // Forced free-run and holdover must win once the write has settled
  a_forced_free: assert property (
    md_r == 2'h2 && cnt_r == 3'h7 |-> st == 3'h0 && !loop_bw_en_o)
    else $error("forced free-run not held");
  a_forced_hold: assert property (
    md_r == 2'h3 && cnt_r == 3'h7 |-> st == 3'h3)
    else $error("forced holdover not held");
  a_bw_locked: assert property (
    loop_bw_en_o == (st == 3'h2))
    else $error("loop filter enabled outside locked");
endmodule // dpllms_checker

bind dpllms_top dpllms_checker chk_u (.clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .dpll_state_o,
  .loop_bw_en_o);

// [sim/dpll_mode_state_machine_bench.sv]
`timescale 1ns/100ps
module dpll_mode_state_machine_bench;
  logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, e;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic        pready_o, pslverr_o, loop_bw_en_o, combo_follow_o;
  logic        apll_lock_pin_o, sys_dpll_locked_o, sel_valid_o;
  logic [2:0]  dpll_state_o, sel_ref_o, damping_o;
  logic [4:0]  bw_index_o;
  logic [47:0] fb_num_o, fb_den_o;
  logic [9:0]  run;
  logic [8:0]  ref_w;
  logic [7:0]  perr;
  int          err_total = 0, num_checks = 0, cyc = 0;

  // Short frequency windows keep qualification quick
  dpllms_top #(.FREQ_SHORT_CYC(64), .FREQ_LONG_CYC(128)) dut_u (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ref_i(ref_w[6:0]),
    .apll_ref_i(ref_w[7]), .auxiliary_oscillator_input_i(ref_w[8]),
    .dpll_phase_lock_i(run[9]), .apll_phase_err_i(perr),
    .dpll_state_o, .sel_ref_o, .sel_valid_o, .loop_bw_en_o, .bw_index_o,
    .damping_o, .combo_follow_o, .apll_lock_pin_o, .sys_dpll_locked_o,
    .fb_num_o, .fb_den_o);
  dpllms_ref_src src_u (.clk_i, .run_i(run[8:0]), .ref_o(ref_w));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the hang guard ends a wait that never sees pready
    do @(posedge clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    chk(pready_o, 1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Wait for state, or for the chosen input when sel is set
  task automatic ws(input logic [2:0] s, input bit sel);
    repeat (3000) begin
      @(negedge clk_i);
      if ((sel ? sel_ref_o : dpll_state_o) === s) break;
    end
    chk(sel ? sel_ref_o : dpll_state_o, s);
  endtask

  // Poll status until input b is qualified
  task automatic wq(input int b);
    repeat (300) begin
      apb(1'b0, dpllms_pkg::STAT_OFF, 32'h0);
      if (q[16+b] === 1'b1) break;
    end
    chk(q[16+b], 1);
  endtask

  // Bits 0..8 start or stop sources, bit 9 is the loop lock level
  task automatic flip(input logic [9:0] m);
    @(posedge clk_i);
    run <= run ^ m;
  endtask

  task automatic t_reset();
    chk(dpll_state_o, 0);
    apb(1'b0, dpllms_pkg::PRIO_OFF, 32'h0);
    chk(q, dpllms_pkg::PRIO_RST);
    apb(1'b0, dpllms_pkg::REFEN_OFF, 32'h0);
    chk(q, dpllms_pkg::REFEN_RST);
    apb(1'b0, 8'h3c, 32'h0);
    chk({e, q}, 33'h1_0000_0000);
    apb(1'b1, dpllms_pkg::FNOM_OFF, 32'd32);
    apb(1'b1, dpllms_pkg::FTOL_OFF, 32'd4);
    apb(1'b1, dpllms_pkg::LOSWIN_OFF, 32'h3);
    apb(1'b0, dpllms_pkg::LOSWIN_OFF, 32'h0);
    chk(q, 32'(dpllms_pkg::LOSWIN_MIN));
    apb(1'b0, dpllms_pkg::MON_OFF, 32'h0);
    chk({q[24], q[14:0]}, 16'h007f);
  endtask

  task automatic t_auto();
    flip(10'h001);
    ws(3'h1, 1'b0);
    chk(sel_valid_o, 1);
    flip(10'h001);
    ws(3'h0, 1'b0);
    flip(10'h001);
    ws(3'h1, 1'b0);
    flip(10'h002);
    wq(1);
    flip(10'h001);
    ws(3'h1, 1'b1);
    chk(dpll_state_o, 1);
    flip(10'h200);
    ws(3'h2, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(loop_bw_en_o, 1);
  endtask

  task automatic t_switch();
    flip(10'h001);
    wq(0);
    chk(sel_ref_o, 1);
    flip(10'h202);
    ws(3'h4, 1'b0);
    flip(10'h200);
    ws(3'h2, 1'b0);
    flip(10'h201);
    ws(3'h3, 1'b0);
    flip(10'h004);
    ws(3'h4, 1'b0);
    flip(10'h004);
    ws(3'h3, 1'b0);
    flip(10'h004);
    ws(3'h4, 1'b0);
    flip(10'h008);
    wq(3);
    flip(10'h004);
    ws(3'h3, 1'b1);
    chk(dpll_state_o, 4);
    flip(10'h200);
    ws(3'h2, 1'b0);
    apb(1'b1, dpllms_pkg::CTRL_OFF, 32'h4);
    flip(10'h002);
    ws(3'h1, 1'b1);
    apb(1'b1, dpllms_pkg::CTRL_OFF, 32'h38);
    ws(3'h3, 1'b1);
  endtask

  // Forced modes, then divider access in and out of free-run
  task automatic t_force();
    apb(1'b1, dpllms_pkg::CTRL_OFF, 32'h3);
    ws(3'h3, 1'b0);
    repeat (300) @(posedge clk_i);
    chk(dpll_state_o, 3);
    apb(1'b1, dpllms_pkg::CTRL_OFF, 32'h1);
    ws(3'h2, 1'b0);
    apb(1'b1, dpllms_pkg::CTRL_OFF, 32'he02);
    ws(3'h0, 1'b0);
    repeat (40) @(posedge clk_i);
    chk({combo_follow_o, apll_lock_pin_o, sys_dpll_locked_o}, 3'h7);
    @(posedge clk_i);
    perr <= 8'hff;
    repeat (3) @(negedge clk_i);
    chk(apll_lock_pin_o, 0);
    @(posedge clk_i);
    perr <= 8'h00;
    apb(1'b1, dpllms_pkg::NUMLO_OFF, 32'h1234_5678);
    apb(1'b1, dpllms_pkg::DENHI_OFF, 32'h0000_abcd);
    // Divider outputs follow the landed write one edge later
    repeat (2) @(negedge clk_i);
    chk({e, fb_den_o[47:32], fb_num_o[31:0]}, 49'h0_abcd_1234_5678);
    apb(1'b1, dpllms_pkg::CTRL_OFF, 32'h0);
    ws(3'h2, 1'b0);
    apb(1'b1, dpllms_pkg::NUMLO_OFF, 32'h0);
    chk({e, fb_num_o[31:0]}, 33'h1_1234_5678);
  endtask

  // Requests on, just below and below the nominal steps
  task automatic t_bw();
    logic [31:0] rq [6] = '{926, 2779, 2780, 500, 121000000, 120999999};
    logic [4:0]  ix [6] = '{0, 0, 1, 0, 16, 15};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, dpllms_pkg::BW_OFF, rq[i]);
      apb(1'b0, dpllms_pkg::BW_OFF, 32'h0);
      chk({q[4:0], bw_index_o}, {ix[i], ix[i]});
      chk({q[10:8], damping_o}, {rq[i][10:8], rq[i][10:8]});
    end
  endtask

  // Main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, rst_n_i} = 4'h0;
    paddr_i = 8'h00;
    perr = 8'h00;
    pwdata_i = 32'h0;
    run = 10'h180;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_auto();
    t_switch();
    t_force();
    t_bw();
    finish_test();
  end
endmodule // dpll_mode_state_machine_bench
